//--- uart_rx_err_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef UART_RX_ERR_MAP_SVH
`define UART_RX_ERR_MAP_SVH
`define ADDR_STATUS 3'h0
`define ADDR_DATA 3'h1
`define ADDR_CTRL 3'h2
`define ADDR_BAUD 3'h3
`define ADDR_COUNT 3'h4
`define CTRL_RECEIVER_ENABLE 0
`define CTRL_NINE 1
`define CTRL_PARITY_ENABLE 2
`define CTRL_PTYPE_LO 3
`define CTRL_PTYPE_HI 4
`define CTRL_TWOSTOP 5
`define CTRL_ADDRESS_DETECT_ENABLE 6
`define CTRL_RIE 7
`define CTRL_TEIE 8
`define CTRL_TIIE 9
`define CTRL_WAKE 10
`define CTRL_TRIG_LO 11
`define CTRL_TRIG_HI 12
`define CTRL_RESET 16'h0000
`define BAUD_RESET 16'h0035
`define OVERSAMPLE_LAST 4'hf
`define SAMPLE_A 4'h7
`define SAMPLE_B 4'h8
`define SAMPLE_MID 4'h9
`define PTYPE_EVEN 2'h0
`define PTYPE_ODD 2'h1
`define PTYPE_MARK 2'h2
`endif

//--- uart_rx_err_pkg.sv
// types shared by the receiver status and interrupt logic
package uart_rx_err_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP1 = 3'b100,
    ST_STOP2 = 3'b101,
    ST_WAIT_HIGH = 3'b110
  } rx_state_t;
  typedef struct packed {
    logic parity_error_flag;
    logic frame_error_flag;
    logic [8:0] data;
  } rx_word_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
  } bus_req_t;
endpackage

//--- uart_rx_err.sv
// receive status, error flags, fifo and combined interrupt of the uart
`timescale 1ns/100ps
`include "uart_rx_err_map.svh"
// How it works
// - a break is received as a frame with low stop bit, so a framing error.
// - long break ends after data plus stop bits; sets flags, stores zeros, interrupts.
// - after a low stop bit the receiver waits for a high line before new start.
// - idle flag low from start detection until stop sampled, high otherwise.
// - word into buffer sets data available; receive interrupt and overrun interrupt.
// - four-entry fifo; overrun when a further word completes while fifo full.
// - on overrun set flag, keep fifo contents, drop the new word, interrupt.
// - overrun clears only after status read followed by data read.
// - noise flag rises with data available; word still stored; no own interrupt.
// - noise flag clears after status read followed by data read.
// - framing error when any selected stop bit samples low.
// - framing and parity errors stored with the word and cleared by reset.
// - parity error on mismatch of selected type, only when parity enabled.
// - combined interrupt is a low pulse from tx empty, tx idle, rx, overrun, address, wake.
// - tx sources have own enables; rx trigger and overrun share one enable.
// - with clock stopped, wake and rx enables set, falling rx edge interrupts.
// - status flags are read only; overrun and noise clear only through a status read followed by a data read.
// - with address detect, rx interrupt only when top received bit is one.
// - without address detect, rx interrupt each time a stored word brings the fifo level to at least the trigger setting plus one.
// - data available clears when a data read empties buffer; no status access needed.
// - sixteen times oversampling, bit level by majority of three samples.
module uart_rx_err #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // serial line and system
  input wire logic rxPin,
  input wire logic clkStopped,
  input wire logic txBufEmpty,
  input wire logic txIdle,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // interrupt
  output logic uartInt_n
);
  localparam int PW = $clog2(FIFO_DEPTH);

  if (FIFO_DEPTH != 4) begin : g_depth_check
    $error("fifo depth must be four");
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [15:0] ctrl;
  logic [15:0] baudDiv;
  uart_rx_err_pkg::bus_req_t req;

  assign req = '{addr: {13'h0000, regAddr}, wdata: regWdata};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `CTRL_RESET;
      baudDiv <= `BAUD_RESET;
    end else if (regWrite) begin
      if (req.addr[2:0] == `ADDR_CTRL) begin
        ctrl <= req.wdata;
      end
      if (req.addr[2:0] == `ADDR_BAUD) begin
        baudDiv <= req.wdata;
      end
    end
  end

  logic receiver_enable;
  logic nineBit;
  logic parEn;
  logic [1:0] parType;
  logic twoStop;
  logic addrDet;
  logic rxIntEn;
  logic [1:0] trigSel;

  assign receiver_enable = ctrl[`CTRL_RECEIVER_ENABLE];
  assign nineBit = ctrl[`CTRL_NINE];
  assign parEn = ctrl[`CTRL_PARITY_ENABLE];
  assign parType = ctrl[`CTRL_PTYPE_HI:`CTRL_PTYPE_LO];
  assign twoStop = ctrl[`CTRL_TWOSTOP];
  assign addrDet = ctrl[`CTRL_ADDRESS_DETECT_ENABLE];
  assign rxIntEn = ctrl[`CTRL_RIE];
  assign trigSel = ctrl[`CTRL_TRIG_HI:`CTRL_TRIG_LO];

  // ----------------------------------------
  // oversampling tick
  // ----------------------------------------
  logic [15:0] divCnt;
  logic tick;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt <= 16'h0000;
      tick <= 1'b0;
    end else if (divCnt >= baudDiv) begin
      divCnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      divCnt <= divCnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // receive state machine
  // ----------------------------------------
  uart_rx_err_pkg::rx_state_t state;
  logic [3:0] sampleCnt;
  logic [1:0] samples;
  logic [3:0] bitIdx;
  logic [8:0] shiftReg;
  logic frameNoise;
  logic parBad;
  logic wordDone;
  uart_rx_err_pkg::rx_word_t doneWord;
  logic doneNoise;
  logic vote;
  logic disagree;
  logic mid;
  logic expPar;
  logic [8:0] nextShift;

  assign vote = (samples[1] & samples[0]) | (samples[1] & rxPin) | (samples[0] & rxPin);
  assign disagree = !((samples[1] == samples[0]) && (samples[0] == rxPin));
  assign mid = tick && (sampleCnt == `SAMPLE_MID);
  assign nextShift = nineBit ? {vote, shiftReg[8:1]} : {1'b0, vote, shiftReg[7:1]};

  always_comb begin
    unique case (parType)
      `PTYPE_EVEN: expPar = ^(nineBit ? shiftReg : {1'b0, shiftReg[7:0]});
      `PTYPE_ODD: expPar = ~^(nineBit ? shiftReg : {1'b0, shiftReg[7:0]});
      `PTYPE_MARK: expPar = 1'b1;
      default: expPar = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      samples <= 2'h0;
    end else if (tick && (sampleCnt == `SAMPLE_A || sampleCnt == `SAMPLE_B)) begin
      samples <= {samples[0], rxPin};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= uart_rx_err_pkg::ST_IDLE;
      sampleCnt <= 4'h0;
      bitIdx <= 4'h0;
      shiftReg <= 9'h000;
      frameNoise <= 1'b0;
      parBad <= 1'b0;
      wordDone <= 1'b0;
      doneWord <= '0;
      doneNoise <= 1'b0;
    end else begin
      wordDone <= 1'b0;
      if (tick) begin
        sampleCnt <= sampleCnt + 4'h1;
      end
      if (mid && disagree) begin
        frameNoise <= 1'b1;
      end
      if (!receiver_enable) begin
        state <= uart_rx_err_pkg::ST_IDLE;
      end else begin
        unique case (state)
          uart_rx_err_pkg::ST_IDLE: begin
            if (!rxPin) begin
              state <= uart_rx_err_pkg::ST_START;
              sampleCnt <= 4'h0;
              frameNoise <= 1'b0;
              parBad <= 1'b0;
            end
          end
          uart_rx_err_pkg::ST_START: begin
            if (mid) begin
              bitIdx <= 4'h0;
              state <= vote ? uart_rx_err_pkg::ST_IDLE : uart_rx_err_pkg::ST_DATA;
            end
          end
          uart_rx_err_pkg::ST_DATA: begin
            if (mid) begin
              shiftReg <= nextShift;
              bitIdx <= bitIdx + 4'h1;
              if (bitIdx == (nineBit ? 4'h8 : 4'h7)) begin
                state <= parEn ? uart_rx_err_pkg::ST_PARITY : uart_rx_err_pkg::ST_STOP1;
              end
            end
          end
          uart_rx_err_pkg::ST_PARITY: begin
            if (mid) begin
              parBad <= (vote != expPar);
              state <= uart_rx_err_pkg::ST_STOP1;
            end
          end
          uart_rx_err_pkg::ST_STOP1, uart_rx_err_pkg::ST_STOP2: begin
            if (mid) begin
              if (!vote) begin
                doneWord.frame_error_flag <= 1'b1;
              end else if (state == uart_rx_err_pkg::ST_STOP1) begin
                doneWord.frame_error_flag <= 1'b0;
              end
              if (twoStop && state == uart_rx_err_pkg::ST_STOP1) begin
                state <= uart_rx_err_pkg::ST_STOP2;
              end else begin
                wordDone <= 1'b1;
                doneWord.data <= shiftReg;
                doneWord.parity_error_flag <= parBad && parEn;
                doneNoise <= frameNoise || disagree;
                if (!vote || doneWord.frame_error_flag) begin
                  state <= uart_rx_err_pkg::ST_WAIT_HIGH;
                end else begin
                  state <= uart_rx_err_pkg::ST_IDLE;
                end
              end
            end
          end
          uart_rx_err_pkg::ST_WAIT_HIGH: begin
            if (rxPin) begin
              state <= uart_rx_err_pkg::ST_IDLE;
            end
          end
          default: state <= uart_rx_err_pkg::ST_IDLE;
        endcase
      end
    end
  end

  logic rxIdle;
  assign rxIdle = (state == uart_rx_err_pkg::ST_IDLE) || (state == uart_rx_err_pkg::ST_WAIT_HIGH);

  // ----------------------------------------
  // receive fifo
  // ----------------------------------------
  uart_rx_err_pkg::rx_word_t mem [FIFO_DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic full;
  logic push;
  logic pop;
  logic dataRd;
  logic statusRd;

  assign full = (count == (PW+1)'(FIFO_DEPTH));
  assign dataRd = regRead && (regAddr == `ADDR_DATA);
  assign statusRd = regRead && (regAddr == `ADDR_STATUS);
  assign push = wordDone && (!full || dataRd);
  assign pop = dataRd && (count != '0);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= doneWord;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (!receiver_enable) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end

  // ----------------------------------------
  // status flags and read sequence
  // ----------------------------------------
  logic statusSeen;
  logic overrun;
  logic noise;
  logic overrunEvt;
  logic seqClear;

  assign overrunEvt = wordDone && full && !dataRd;
  assign seqClear = dataRd && statusSeen;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      statusSeen <= 1'b0;
    end else if (statusRd) begin
      statusSeen <= 1'b1;
    end else if (dataRd) begin
      statusSeen <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun <= 1'b0;
      noise <= 1'b0;
    end else begin
      if (overrunEvt) begin
        overrun <= 1'b1;
      end else if (seqClear) begin
        overrun <= 1'b0;
      end
      if (push && doneNoise) begin
        noise <= 1'b1;
      end else if (seqClear) begin
        noise <= 1'b0;
      end
    end
  end

  logic dataAvail;
  uart_rx_err_pkg::rx_word_t head;
  assign dataAvail = (count != '0);
  assign head = dataAvail ? mem[rdPtr] : '0;

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      unique case (regAddr)
        `ADDR_STATUS: regRdata <= {8'h00, txIdle, txBufEmpty, rxIdle, head.parity_error_flag, head.frame_error_flag, noise, overrun, dataAvail};
        `ADDR_DATA: regRdata <= {7'h00, head.data};
        `ADDR_CTRL: regRdata <= ctrl;
        `ADDR_BAUD: regRdata <= baudDiv;
        `ADDR_COUNT: regRdata <= 16'((count));
        default: regRdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // combined interrupt
  // ----------------------------------------
  logic trigHit;
  logic addrOk;
  logic rxPrev;
  logic wakeEvt;
  logic reqLevel;
  logic reqPrev;
  logic rxEvt;

  assign trigHit = count >= ({1'b0, trigSel} + 3'h1);
  assign addrOk = !addrDet || (nineBit ? doneWord.data[8] : doneWord.data[7]);
  assign rxEvt = push && rxIntEn && addrOk && (addrDet || trigHit || count + 1'b1 >= {1'b0, trigSel} + 3'h1);
  assign wakeEvt = clkStopped && ctrl[`CTRL_WAKE] && rxIntEn && rxPrev && !rxPin;
  assign reqLevel = (txBufEmpty && ctrl[`CTRL_TEIE]) || (txIdle && ctrl[`CTRL_TIIE])
    || (rxIntEn && overrun);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxPrev <= 1'b1;
      reqPrev <= 1'b0;
      uartInt_n <= 1'b1;
    end else begin
      rxPrev <= rxPin;
      reqPrev <= reqLevel;
      uartInt_n <= !((reqLevel && !reqPrev) || rxEvt || wakeEvt);
    end
  end

endmodule // uart_rx_err

//--- uart_line_model.sv
// serial transmitter model driving the receive line
`timescale 1ns/100ps
module uart_line_model (
  // clock
  input wire logic clk,
  // line, idle high
  output logic rxPin
);
  initial rxPin = 1'b1;
  // start bit, n bits lsb first, 16 clocks each; glitch flips one sample of bit 0
  task automatic send(input logic [11:0] b, input int n, input bit g);
    rxPin <= 1'b0;
    repeat (16) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxPin <= b[i];
      repeat (9) @(posedge clk);
      if (g && i == 0) rxPin <= ~b[i];
      @(posedge clk);
      rxPin <= b[i];
      repeat (6) @(posedge clk);
    end
    rxPin <= 1'b1;
  endtask
  // plain low level, break or wake edge
  task automatic low(input int c);
    rxPin <= 1'b0;
    repeat (c) @(posedge clk);
    rxPin <= 1'b1;
  endtask
endmodule // uart_line_model

//--- uart_rx_err_chk.sv
// port assertions of the receiver status and interrupt block
`timescale 1ns/100ps
module uart_rx_err_chk (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // line and system
  input wire logic rxPin,
  input wire logic clkStopped,
  input wire logic txBufEmpty,
  input wire logic txIdle,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdata,
  // interrupt
  input wire logic uartInt_n
);
  logic [15:0] ctrl;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ctrl <= 16'h0000;
    else if (regWrite && regAddr == 3'h2) ctrl <= regWdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_pulse;
    $fell(uartInt_n) |=> uartInt_n;
  endproperty
  a_pulse: assert property (p_pulse) else $error("interrupt pulse too long");
  property p_wake;
    clkStopped && ctrl[10] && ctrl[7] && $fell(rxPin) |-> ##[0:3] !uartInt_n;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake interrupt");
  property p_quiet;
    ctrl[10:7] == 4'h0 && $past(ctrl[10:7]) == 4'h0 && $past(ctrl[10:7], 2) == 4'h0 |-> uartInt_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt with all enables off");
  property p_txe;
    $rose(txBufEmpty) && ctrl[8] |-> ##[0:2] !uartInt_n;
  endproperty
  a_txe: assert property (p_txe) else $error("no tx empty interrupt");
  property p_txi;
    $rose(txIdle) && ctrl[9] |-> ##[0:2] !uartInt_n;
  endproperty
  a_txi: assert property (p_txi) else $error("no tx idle interrupt");
  property p_stat;
    regRead && regAddr == 3'h0 |=> regRdata[7] == $past(txIdle) && regRdata[6] == $past(txBufEmpty);
  endproperty
  a_stat: assert property (p_stat) else $error("status tx bits wrong");
  property p_unmap;
    regRead && regAddr > 3'h4 |=> regRdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_count;
    regRead && regAddr == 3'h4 |=> regRdata <= 16'h0004;
  endproperty
  a_count: assert property (p_count) else $error("fifo count above four");
endmodule // uart_rx_err_chk
bind uart_rx_err uart_rx_err_chk u_chk (.clk(clk), .arst_n(arst_n), .rxPin(rxPin),
  .clkStopped(clkStopped), .txBufEmpty(txBufEmpty), .txIdle(txIdle), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .uartInt_n(uartInt_n));

//--- uart_rx_err_tb.sv
// self-checking bench of the receiver status and interrupt block
`timescale 1ns/100ps
module uart_rx_err_tb;
  logic clk, arst_n, rxPin, clkStopped, txBufEmpty, txIdle, regWrite, regRead, uartInt_n;
  logic [2:0] regAddr;
  logic [15:0] regWdata, regRdata, got;
  int nErrors = 0, testsRun = 0, ints = 0, cyc = 0;
  uart_line_model u_line (.clk(clk), .rxPin(rxPin));
  uart_rx_err u_dut (.clk(clk), .arst_n(arst_n), .rxPin(rxPin), .clkStopped(clkStopped),
    .txBufEmpty(txBufEmpty), .txIdle(txIdle), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .uartInt_n(uartInt_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // pulse count and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (uartInt_n === 1'b0) ints <= ints + 1;
    if (cyc == 20000) begin
      nErrors++;
      stopTest();
    end
  end
  task automatic stopTest();
    $display("errors %0d checks %0d", nErrors, testsRun);
    if (nErrors == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    testsRun++;
    if (g !== e) begin
      nErrors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    got = regRdata;
  endtask
  task automatic rx(input logic [11:0] b, input int n, input bit g);
    u_line.send(b, n, g);
    repeat (4) @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_basic();
    int i0;
    rd(3'h3); chk(got, 16'h0035);
    rd(3'h0); chk(got, 16'h0020);
    wr(3'h0, 16'hffff);
    rd(3'h5); chk(got, 16'h0000);
    rd(3'h0); chk(got, 16'h0020);
    wr(3'h3, 16'h0000);
    wr(3'h2, 16'h0081);
    i0 = ints;
    fork
      rx(12'h1a5, 9, 0);
      begin repeat (60) @(posedge clk); rd(3'h0); chk(got, 16'h0000); end
    join
    chk(16'(ints - i0), 16'h0001);
    rd(3'h0); chk(got, 16'h0021);
    rd(3'h1); chk(got, 16'h00a5);
    rd(3'h0); chk(got, 16'h0020);
    i0 = ints;
    rx(12'h155, 9, 1);
    chk(16'(ints - i0), 16'h0001);
    rd(3'h0); chk(got, 16'h0025);
    rd(3'h1); chk(got, 16'h0055);
    rd(3'h0); chk(got, 16'h0020);
  endtask
  task automatic t_errors();
    logic p;
    rx(12'h03c, 9, 0);
    rd(3'h0); chk(got & 16'h001f, 16'h0009);
    rd(3'h1); chk(got, 16'h003c);
    wr(3'h2, 16'h00a1);
    rx(12'h1ff, 10, 0);
    rd(3'h0); chk(got & 16'h001f, 16'h0009);
    rd(3'h1);
    rx(12'h3ff, 10, 0);
    rd(3'h0); chk(got & 16'h001f, 16'h0001);
    rd(3'h1);
    for (int t = 0; t < 8; t++) begin
      p = ((t[2:1] == 2'h0) || (t[2:1] == 2'h2)) ^ t[0];
      wr(3'h2, {8'h00, 3'h4, t[2:1], 3'h5});
      rx({2'h0, 1'b1, p, 8'h01}, 10, 0);
      rd(3'h0); chk(got & 16'h0011, {11'h000, t[0], 4'h1});
      rd(3'h1); chk(got, 16'h0001);
    end
  endtask
  task automatic t_break();
    int i0;
    wr(3'h2, 16'h0081);
    i0 = ints;
    u_line.low(480);
    repeat (40) @(posedge clk);
    chk(16'(ints - i0), 16'h0001);
    rd(3'h4); chk(got, 16'h0001);
    rd(3'h0); chk(got & 16'h002b, 16'h0029);
    rd(3'h1); chk(got, 16'h0000);
  endtask
  task automatic t_overrun();
    int i0;
    i0 = ints;
    for (int k = 0; k < 5; k++) rx(12'h110 + 12'(k), 9, 0);
    chk(16'(ints - i0), 16'h0005);
    rd(3'h4); chk(got, 16'h0004);
    rd(3'h0); chk(got & 16'h0003, 16'h0003);
    for (int k = 0; k < 4; k++) begin
      rd(3'h1); chk(got, 16'h0010 + 16'(k));
    end
    rd(3'h0); chk(got & 16'h0003, 16'h0000);
    wr(3'h2, 16'h0881);
    i0 = ints;
    rx(12'h101, 9, 0);
    chk(16'(ints - i0), 16'h0000);
    rx(12'h102, 9, 0);
    chk(16'(ints - i0), 16'h0001);
    rd(3'h1); chk(got, 16'h0001);
    rd(3'h1); chk(got, 16'h0002);
  endtask
  task automatic t_int();
    int i0;
    wr(3'h2, 16'h00c1);
    i0 = ints;
    rx(12'h17f, 9, 0);
    chk(16'(ints - i0), 16'h0000);
    rx(12'h180, 9, 0);
    chk(16'(ints - i0), 16'h0001);
    wr(3'h2, 16'h00c3);
    rx(12'h2ff, 10, 0);
    chk(16'(ints - i0), 16'h0001);
    rd(3'h0); rd(3'h1); rd(3'h1); rd(3'h1);
    wr(3'h2, 16'h0480);
    clkStopped <= 1'b1;
    i0 = ints;
    u_line.low(4);
    repeat (4) @(posedge clk);
    chk(16'(ints - i0), 16'h0001);
    clkStopped <= 1'b0;
    wr(3'h2, 16'h0100);
    txBufEmpty <= 1'b1;
    repeat (4) @(posedge clk);
    wr(3'h2, 16'h0200);
    txIdle <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'(ints - i0), 16'h0003);
    rd(3'h0); chk(got & 16'h00c0, 16'h00c0);
  endtask
  initial begin
    arst_n = 1'b0;
    clkStopped = 1'b0;
    txBufEmpty = 1'b0;
    txIdle = 1'b0;
    regAddr = 3'h0;
    regWdata = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_basic();
    t_errors();
    t_break();
    t_overrun();
    t_int();
    stopTest();
  end
endmodule // uart_rx_err_tb
